/* File: src/fault_event_logger.v */
// What this block does
// - The alarm log keeps the latest 20 alarms, warnings and trouble codes in storage kept over power loss.
// - A new fault on a full alarm log overwrites the oldest entry.
// - Each alarm entry holds a time stamp and six measurements taken at the fault.
// - Two alarm slots are fixed to coolant temperature and oil pressure, changed only at security level 2 or above.
// - The other measurement slots select among analog inputs, digital inputs and output functions.
// - Every alarm, warning, trouble code and sensor failure is logged with no filtering, except a fault in the one restore cycle after reset.
// - The alarm log is read both over the remote link and on the local display.
// - Remote alarm reads return entries newest first.
// - The event log lives in volatile storage and is lost when power goes.
// - The event log holds 20 entries and a new event on a full log replaces the oldest.
// - A digital event source logs an event each time it changes to the set level.
// - An analog event source logs an event when its compare against the setpoint comes true.
// - Each event entry holds a time stamp and six selected measurements.
// - The event log is read only over the remote link, newest first, never on the display.
`timescale 1ns/1ps
`include "fault_event_logger_defs.vh"
module fault_event_logger (
	input  wire                     clock_in,
	input  wire                     rstn_in,
	input  wire [`TS_W-1:0]         timestamp_in,
	input  wire [`ANALOG_BUS_W-1:0] analog_in,
	input  wire [`DIG_W-1:0]        digital_in,
	input  wire [`OUTFN_W-1:0]      outfn_in,
	input  wire [`SEL_VEC_W-1:0]    meas_sel_in,
	input  wire                     fixed_sel_we_in,
	input  wire [1:0]               security_level_in,
	input  wire [`SRC_W-1:0]        fixed_coolant_sel_in,
	input  wire [`SRC_W-1:0]        fixed_oil_sel_in,
	input  wire                     fault_strobe_in,
	input  wire [`KIND_W-1:0]       fault_kind_in,
	input  wire [`CODE_W-1:0]       fault_code_in,
	input  wire [`PTR_W-1:0]        nv_ptr_in,
	input  wire [`PTR_W-1:0]        nv_count_in,
	input  wire                     ev_enable_in,
	input  wire [`SRC_W-1:0]        ev_src_in,
	input  wire                     ev_level_in,
	input  wire [`MEAS_W-1:0]       ev_setpoint_in,
	input  wire [1:0]               ev_cmp_in,
	input  wire                     rd_req_in,
	input  wire                     rd_log_in,
	input  wire [`PTR_W-1:0]        rd_index_in,
	input  wire                     disp_req_in,
	input  wire [`PTR_W-1:0]        disp_index_in,
	output reg                      rd_valid_out,
	output reg                      rd_empty_out,
	output reg  [`ENTRY_W-1:0]      rd_data_out,
	output reg                      disp_valid_out,
	output reg                      disp_empty_out,
	output reg  [`ENTRY_W-1:0]      disp_data_out,
	output reg  [`PTR_W-1:0]        alarm_ptr_out,
	output reg  [`PTR_W-1:0]        alarm_count_out,
	output reg  [`PTR_W-1:0]        event_count_out,
	output reg  [`SRC_W-1:0]        coolant_src_out,
	output reg  [`SRC_W-1:0]        oil_src_out
);

	reg  [`PTR_W-1:0]   event_ptr;
	reg                 restored;
	reg                 ev_hold_prev;
	reg                 rd_pend;
	reg                 rd_pend_log;
	reg                 rd_pend_empty;
	reg                 disp_pend;
	reg                 disp_pend_empty;
	wire [`ENTRY_W-1:0] alarm_q;
	wire [`ENTRY_W-1:0] event_q;

	function [`MEAS_W-1:0] meas_value;
		input [`SRC_W-1:0]        sel;
		input [`ANALOG_BUS_W-1:0] ana;
		input [`DIG_W-1:0]        dig;
		input [`OUTFN_W-1:0]      outf;
		reg   [`SRC_W-1:0]        k;
		begin
			k = sel;
			meas_value = `MEAS_ZERO;
			if (sel < `SRC_DIG_BASE) begin
				meas_value = ana[sel*`MEAS_W +: `MEAS_W];
			end else if (sel < `SRC_OUT_BASE) begin
				k = sel - `SRC_DIG_BASE;
				meas_value = {`BIT_PAD, dig[k[3:0]]};
			end else if (sel < `SRC_LIMIT) begin
				k = sel - `SRC_OUT_BASE;
				meas_value = {`BIT_PAD, outf[k[3:0]]};
			end
		end
	endfunction

	function [`PTR_W-1:0] wrap_inc;
		input [`PTR_W-1:0] p;
		begin
			wrap_inc = (p == `PTR_LAST) ? `PTR_ZERO : p + 5'h01;
		end
	endfunction

	function [`PTR_W-1:0] sat_inc;
		input [`PTR_W-1:0] c;
		begin
			sat_inc = (c == `LOG_DEPTH) ? c : c + 5'h01;
		end
	endfunction

	// Index 0 is the newest entry, which sits just behind the write pointer.
	function [`PTR_W-1:0] newest_addr;
		input [`PTR_W-1:0] p;
		input [`PTR_W-1:0] idx;
		reg   [5:0]        t;
		begin
			t = {1'b0, p} + `ADDR_DEPTH - `ADDR_ONE - {1'b0, idx};
			if (t >= `ADDR_DEPTH)
				t = t - `ADDR_DEPTH;
			newest_addr = t[`PTR_W-1:0];
		end
	endfunction

	// Measurements and stamp are built combinationally so the write sees this cycle's values.
	wire [`MEAS_VEC_W-1:0] meas_vec = {
		meas_value(meas_sel_in[23:18], analog_in, digital_in, outfn_in),
		meas_value(meas_sel_in[17:12], analog_in, digital_in, outfn_in),
		meas_value(meas_sel_in[11:6], analog_in, digital_in, outfn_in),
		meas_value(meas_sel_in[5:0], analog_in, digital_in, outfn_in),
		meas_value(oil_src_out, analog_in, digital_in, outfn_in),
		meas_value(coolant_src_out, analog_in, digital_in, outfn_in)};

	wire [`ENTRY_W-1:0] alarm_entry = {timestamp_in, fault_kind_in, fault_code_in, meas_vec};
	wire [`ENTRY_W-1:0] event_entry = {timestamp_in, `KIND_EVENT, ev_src_in, meas_vec};

	// Faults are held off in the one cycle that reloads the saved pointer after reset.
	wire alarm_wr = fault_strobe_in && restored;

	wire [`MEAS_W-1:0] ev_value = meas_value(ev_src_in, analog_in, digital_in, outfn_in);
	wire ev_analog = ev_src_in < `SRC_DIG_BASE;
	reg  ev_cmp_true;
	always @* begin
		case (ev_cmp_in)
			`CMP_LT: ev_cmp_true = ev_value < ev_setpoint_in;
			`CMP_GT: ev_cmp_true = ev_value > ev_setpoint_in;
			`CMP_LE: ev_cmp_true = ev_value <= ev_setpoint_in;
			default: ev_cmp_true = ev_value >= ev_setpoint_in;
		endcase
	end
	wire ev_hold = ev_analog ? ev_cmp_true : (ev_value[0] == ev_level_in);
	// Only the transition logs, otherwise a standing condition would flood the log.
	wire event_wr = ev_enable_in && ev_hold && !ev_hold_prev;

	wire rd_alarm = rd_req_in && !rd_log_in;
	wire rd_event = rd_req_in && rd_log_in;
	// The remote link wins the shared read port; a colliding display request is dropped.
	wire disp_take = disp_req_in && !rd_alarm;

	wire [`PTR_W-1:0] alarm_rd_addr = rd_alarm ? newest_addr(alarm_ptr_out, rd_index_in)
	                                           : newest_addr(alarm_ptr_out, disp_index_in);
	wire [`PTR_W-1:0] event_rd_addr = newest_addr(event_ptr, rd_index_in);

	log_mem #(.WIDTH(`ENTRY_W), .DEPTH(20), .AW(`PTR_W)) alarm_mem (
		.clock_in    (clock_in),
		.wr_en_in    (alarm_wr),
		.wr_addr_in  (alarm_ptr_out),
		.wr_data_in  (alarm_entry),
		.rd_en_in    (rd_alarm || disp_take),
		.rd_addr_in  (alarm_rd_addr),
		.rd_data_out (alarm_q)
	);

	log_mem #(.WIDTH(`ENTRY_W), .DEPTH(20), .AW(`PTR_W)) event_mem (
		.clock_in    (clock_in),
		.wr_en_in    (event_wr),
		.wr_addr_in  (event_ptr),
		.wr_data_in  (event_entry),
		.rd_en_in    (rd_event),
		.rd_addr_in  (event_rd_addr),
		.rd_data_out (event_q)
	);

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			restored        <= 1'b0;
			alarm_ptr_out   <= `PTR_ZERO;
			alarm_count_out <= `PTR_ZERO;
			event_ptr       <= `PTR_ZERO;
			event_count_out <= `PTR_ZERO;
			ev_hold_prev    <= 1'b1;
			coolant_src_out <= `DEF_COOLANT_SRC;
			oil_src_out     <= `DEF_OIL_SRC;
		end else begin
			restored     <= 1'b1;
			ev_hold_prev <= ev_hold;
			if (!restored) begin
				alarm_ptr_out   <= (nv_ptr_in > `PTR_LAST) ? `PTR_ZERO : nv_ptr_in;
				alarm_count_out <= (nv_count_in > `LOG_DEPTH) ? `LOG_DEPTH : nv_count_in;
			end else if (alarm_wr) begin
				alarm_ptr_out   <= wrap_inc(alarm_ptr_out);
				alarm_count_out <= sat_inc(alarm_count_out);
			end
			if (event_wr) begin
				event_ptr       <= wrap_inc(event_ptr);
				event_count_out <= sat_inc(event_count_out);
			end
			if (fixed_sel_we_in && security_level_in >= `SEC_FIXED_LEVEL) begin
				coolant_src_out <= fixed_coolant_sel_in;
				oil_src_out     <= fixed_oil_sel_in;
			end
		end
	end

	always @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_pend         <= 1'b0;
			rd_pend_log     <= 1'b0;
			rd_pend_empty   <= 1'b0;
			disp_pend       <= 1'b0;
			disp_pend_empty <= 1'b0;
			rd_valid_out    <= 1'b0;
			rd_empty_out    <= 1'b0;
			rd_data_out     <= `ENTRY_ZERO;
			disp_valid_out  <= 1'b0;
			disp_empty_out  <= 1'b0;
			disp_data_out   <= `ENTRY_ZERO;
		end else begin
			rd_pend       <= rd_req_in;
			rd_pend_log   <= rd_log_in;
			rd_pend_empty <= rd_log_in ? (rd_index_in >= event_count_out)
			                           : (rd_index_in >= alarm_count_out);
			disp_pend       <= disp_take;
			disp_pend_empty <= disp_index_in >= alarm_count_out;
			rd_valid_out    <= rd_pend;
			if (rd_pend) begin
				rd_empty_out <= rd_pend_empty;
				rd_data_out  <= rd_pend_empty ? `ENTRY_ZERO : (rd_pend_log ? event_q : alarm_q);
			end
			disp_valid_out <= disp_pend;
			if (disp_pend) begin
				disp_empty_out <= disp_pend_empty;
				disp_data_out  <= disp_pend_empty ? `ENTRY_ZERO : alarm_q;
			end
		end
	end

endmodule

/* File: src/fault_event_logger_defs.vh */
`ifndef FAULT_EVENT_LOGGER_DEFS_VH
`define FAULT_EVENT_LOGGER_DEFS_VH

`define LOG_DEPTH      5'h14
`define PTR_W          5
`define PTR_ZERO       5'h00
`define PTR_LAST       5'h13
`define ADDR_DEPTH     6'h14
`define ADDR_ONE       6'h01

`define MEAS_W         16
`define MEAS_ZERO      16'h0000
`define BIT_PAD        15'h0000
`define ANALOG_BUS_W   128
`define DIG_W          16
`define OUTFN_W        16
`define SRC_W          6
`define SRC_DIG_BASE   6'h08
`define SRC_OUT_BASE   6'h18
`define SRC_LIMIT      6'h28

`define TS_W           32
`define TS_ZERO        32'h00000000
`define KIND_W         2
`define CODE_W         6
`define KIND_EVENT     2'h0
`define ENTRY_W        136
`define ENTRY_ZERO     136'h0
`define MEAS_VEC_W     96
`define SEL_VEC_W      24

`define CMP_LT         2'h0
`define CMP_GT         2'h1
`define CMP_LE         2'h2
`define CMP_GE         2'h3

`define DEF_COOLANT_SRC 6'h02
`define DEF_OIL_SRC     6'h03
`define SEC_FIXED_LEVEL 2'h2

`endif

/* File: src/log_mem.v */
`timescale 1ns/1ps
module log_mem #(
	parameter WIDTH = 136,
	parameter DEPTH = 20,
	parameter AW    = 5
) (
	input  wire             clock_in,
	input  wire             wr_en_in,
	input  wire [AW-1:0]    wr_addr_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             rd_en_in,
	input  wire [AW-1:0]    rd_addr_in,
	output reg  [WIDTH-1:0] rd_data_out
);

	// No reset on the array: contents are meant to be kept by the storage itself.
	reg [WIDTH-1:0] store [0:DEPTH-1];

	always @(posedge clock_in) begin
		if (wr_en_in)
			store[wr_addr_in] <= wr_data_in;
		if (rd_en_in)
			rd_data_out <= store[rd_addr_in];
	end

endmodule

/* File: verif/fault_event_logger_props.sv */
`timescale 1ns/1ps
module fault_event_logger_props (
	input wire logic       clock_in,
	input wire logic       rstn_in,
	input wire logic       fault_strobe_in,
	input wire logic [4:0] nv_ptr_in,
	input wire logic [4:0] nv_count_in,
	input wire logic       rd_req_in,
	input wire logic       rd_log_in,
	input wire logic [4:0] rd_index_in,
	input wire logic       disp_req_in,
	input wire logic       rd_valid_out,
	input wire logic       rd_empty_out,
	input wire logic       disp_valid_out,
	input wire logic [4:0] alarm_ptr_out,
	input wire logic [4:0] alarm_count_out,
	input wire logic [4:0] event_count_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	logic live;
	wire  beyond = rd_index_in >= (rd_log_in ? event_count_out : alarm_count_out);
	wire  shown  = !(rd_req_in && !rd_log_in);
	// Faults in the restore cycle are dropped, so counting checks start one edge later.
	always @(posedge clock_in or negedge rstn_in)
		if (!rstn_in) live <= 1'b0; else live <= 1'b1;
	sequence s_req; rd_req_in; endsequence
	sequence s_ans; ##2 rd_valid_out; endsequence
	property p_rd_answer; s_req |-> s_ans; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("remote answer missing");
	property p_rd_cause; rd_valid_out |-> $past(rd_req_in, 2); endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("remote answer unasked");
	property p_empty; s_req |-> ##2 rd_empty_out == $past(beyond, 2); endproperty
	a_empty: assert property (p_empty) else $error("empty flag wrong");
	property p_disp; disp_req_in |-> ##2 disp_valid_out == $past(shown, 2); endproperty
	a_disp: assert property (p_disp) else $error("display answer wrong");
	property p_count;
		live && fault_strobe_in |=> alarm_count_out ==
			($past(alarm_count_out) == 5'h14 ? 5'h14 : $past(alarm_count_out) + 5'h01);
	endproperty
	a_count: assert property (p_count) else $error("alarm count step wrong");
	property p_ptr;
		live && fault_strobe_in |=> alarm_ptr_out ==
			($past(alarm_ptr_out) == 5'h13 ? 5'h00 : $past(alarm_ptr_out) + 5'h01);
	endproperty
	a_ptr: assert property (p_ptr) else $error("alarm pointer step wrong");
	property p_still; live && !fault_strobe_in |=> $stable(alarm_ptr_out) && $stable(alarm_count_out);
	endproperty
	a_still: assert property (p_still) else $error("alarm log moved without fault");
	property p_restore;
		!live |=> alarm_ptr_out == ($past(nv_ptr_in) > 5'h13 ? 5'h00 : $past(nv_ptr_in)) &&
			alarm_count_out == ($past(nv_count_in) > 5'h14 ? 5'h14 : $past(nv_count_in));
	endproperty
	a_restore: assert property (p_restore) else $error("alarm log not restored");
	property p_ev_step; event_count_out <= 5'h14 && event_count_out - $past(event_count_out) <= 5'h01;
	endproperty
	a_ev_step: assert property (p_ev_step) else $error("event count step wrong");
endmodule

/* File: verif/log_reader.sv */
`timescale 1ns/1ps
module log_reader (
	input  wire logic         clock_in,
	input  wire logic         valid_in,
	input  wire logic         empty_in,
	input  wire logic [135:0] data_in,
	output logic              req_out,
	output logic              log_out,
	output logic [4:0]        index_out
);
	// Request lines are scrambled when idle so a stale index can never look valid.
	task automatic fetch(input logic lg, input logic [4:0] ix, output logic [135:0] d,
		output logic e, output logic ok);
		ok = 1'b0;
		@(posedge clock_in); #1;
		req_out = 1'b1; log_out = lg; index_out = ix;
		@(posedge clock_in); #1;
		req_out = 1'b0; log_out = ~lg; index_out = ~ix;
		for (int i = 0; i < 6 && !ok; i++) begin
			@(posedge clock_in); #1;
			if (valid_in === 1'b1) begin ok = 1'b1; d = data_in; e = empty_in; end
		end
	endtask
	initial begin req_out = 1'b0; log_out = 1'b0; index_out = 5'h00; end
endmodule

/* File: verif/test_fault_event_logger.sv */
`timescale 1ns/1ps
`include "fault_event_logger_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_fault_event_logger;
	logic clock_in = 1'b0, rstn_in = 1'b0, fixed_sel_we_in, fault_strobe_in, ev_enable_in, ev_level_in;
	logic rd_req_in, rd_log_in, disp_req_in, rd_valid_out, rd_empty_out, disp_valid_out, disp_empty_out;
	logic [31:0] timestamp_in, lfsr = 32'h00000029;
	logic [127:0] analog_in;
	logic [15:0] digital_in, outfn_in, ev_setpoint_in;
	logic [23:0] meas_sel_in;
	logic [1:0] security_level_in, fault_kind_in, ev_cmp_in;
	logic [5:0] fixed_coolant_sel_in, fixed_oil_sel_in, fault_code_in, ev_src_in;
	logic [5:0] coolant_src_out, oil_src_out, cool, oil;
	logic [4:0] nv_ptr_in, nv_count_in, rd_index_in, disp_index_in, ep;
	logic [4:0] alarm_ptr_out, alarm_count_out, event_count_out;
	logic [135:0] rd_data_out, disp_data_out, d, d2, x;
	logic [135:0] hist [0:3];
	logic e, ok, e2, ok2;
	int fail_count = 0, compares = 0;
	logic [15:0] lo [0:3] = '{16'h0064, 16'h0064, 16'h0065, 16'h0063};
	logic [15:0] hi [0:3] = '{16'h0063, 16'h0065, 16'h0064, 16'h0064};
	always #4 clock_in = ~clock_in;
	fault_event_logger uut (.*);
	log_reader remote (.clock_in, .valid_in(rd_valid_out), .empty_in(rd_empty_out),
		.data_in(rd_data_out), .req_out(rd_req_in), .log_out(rd_log_in), .index_out(rd_index_in));
	log_reader panel (.clock_in, .valid_in(disp_valid_out), .empty_in(disp_empty_out),
		.data_in(disp_data_out), .req_out(disp_req_in), .log_out(), .index_out(disp_index_in));
	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function logic [15:0] meas(logic [5:0] s);
		if (s < 6'h08) return analog_in[s * 16 +: 16];
		if (s < 6'h18) return {15'h0000, digital_in[s - 6'h08]};
		if (s < 6'h28) return {15'h0000, outfn_in[s - 6'h18]};
		return 16'h0000;
	endfunction
	function logic [135:0] entry(logic [1:0] k, logic [5:0] c);
		return {timestamp_in, k, c, meas(meas_sel_in[23:18]), meas(meas_sel_in[17:12]),
			meas(meas_sel_in[11:6]), meas(meas_sel_in[5:0]), meas(oil), meas(cool)};
	endfunction
	task step(int n); repeat (n) @(posedge clock_in); #1; endtask
	task randin();
		timestamp_in = rnd();
		for (int j = 0; j < 4; j++) analog_in[j * 32 +: 32] = rnd();
		digital_in = 16'(rnd());
		outfn_in = 16'(rnd());
	endtask
	task fault(logic [1:0] k, output logic [135:0] y);
		randin();
		fault_kind_in = k; fault_code_in = 6'(rnd()); fault_strobe_in = 1'b1;
		y = entry(k, fault_code_in);
		ep = (ep == 5'h13) ? 5'h00 : ep + 5'h01;
		step(1);
	endtask
	task rd(logic p, logic lg, logic [4:0] ix, logic [135:0] y, logic ye);
		if (p) panel.fetch(lg, ix, d, e, ok); else remote.fetch(lg, ix, d, e, ok);
		if (!ok) begin fail_count++; summarize(); end
		`CHK("empty", ye, e)
		`CHK("entry", y, d)
	endtask
	task ev(logic [15:0] f, logic [15:0] t, logic [1:0] c);
		analog_in[15:0] = f; ev_cmp_in = c; step(2);
		randin(); analog_in[15:0] = t; x = entry(2'h0, 6'h00); step(3);
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		{timestamp_in, analog_in, digital_in, outfn_in} = '0;
		meas_sel_in = {6'h28, 6'h19, 6'h09, 6'h00};
		{fixed_sel_we_in, fault_strobe_in, ev_enable_in, ev_level_in} = 4'h1;
		{security_level_in, fault_kind_in, ev_cmp_in, fault_code_in} = '0;
		fixed_coolant_sel_in = 6'h05; fixed_oil_sel_in = 6'h06; ev_src_in = 6'h08;
		nv_ptr_in = 5'h12; nv_count_in = 5'h13; ev_setpoint_in = 16'h0064;
		cool = 6'h02; oil = 6'h03; ep = 5'h12;
		step(5);
		rstn_in = 1'b1; fault_strobe_in = 1'b1; step(1);
		fault_strobe_in = 1'b0; step(1);
		`CHK("ptr", 5'h12, alarm_ptr_out)
		`CHK("count", 5'h13, alarm_count_out)
		$display("restore test done");
		for (int i = 0; i < 4; i++) fault(i, hist[i]);
		fault_strobe_in = 1'b0; step(1);
		`CHK("ptr", 5'h02, alarm_ptr_out)
		`CHK("count", 5'h14, alarm_count_out)
		rd(0, 0, 5'h00, hist[3], 0);
		rd(0, 0, 5'h01, hist[2], 0);
		rd(1, 0, 5'h00, hist[3], 0);
		rd(0, 0, 5'h14, '0, 1);
		// A remote alarm read in the same cycle takes the shared port from the display.
		fork
			remote.fetch(1'b0, 5'h00, d, e, ok);
			panel.fetch(1'b0, 5'h00, d2, e2, ok2);
		join
		`CHK("remote", 1'b1, ok)
		`CHK("entry", hist[3], d)
		`CHK("dropped", 1'b0, ok2)
		$display("alarm test done");
		security_level_in = 2'h1; fixed_sel_we_in = 1'b1; step(1);
		fixed_sel_we_in = 1'b0; step(1);
		`CHK("coolant", 6'h02, coolant_src_out)
		security_level_in = 2'h2; fixed_sel_we_in = 1'b1; step(1);
		fixed_sel_we_in = 1'b0; cool = 6'h05; oil = 6'h06; step(1);
		`CHK("oil", 6'h06, oil_src_out)
		`CHK("coolant", 6'h05, coolant_src_out)
		fault(2'h3, x); fault_strobe_in = 1'b0;
		rd(0, 0, 5'h00, x, 0);
		$display("select test done");
		rd(0, 1, 5'h00, '0, 1);
		// The source starts low, so that the rise below is a real edge.
		ev_enable_in = 1'b1; digital_in[0] = 1'b0; step(2);
		randin(); digital_in[0] = 1'b1; x = entry(2'h0, 6'h08); step(3);
		`CHK("events", 5'h01, event_count_out)
		rd(0, 1, 5'h00, x, 0);
		ev_src_in = 6'h00;
		for (int c = 0; c < 4; c++) begin
			ev(lo[c], hi[c], c);
			`CHK("events", 5'(c + 2), event_count_out)
			rd(0, 1, 5'h00, x, 0);
		end
		$display("event test done");
		for (int i = 0; i < 18; i++) ev(16'h0000, 16'(rnd()) | 16'h0064, 2'h3);
		`CHK("events", 5'h14, event_count_out)
		rd(0, 1, 5'h00, x, 0);
		repeat (25) fault(2'(rnd()), x);
		fault_strobe_in = 1'b0; step(1);
		`CHK("ptr", ep, alarm_ptr_out)
		rd(0, 0, 5'h00, x, 0);
		$display("storm test done");
		nv_ptr_in = ep; nv_count_in = 5'h14; rstn_in = 1'b0; step(2);
		rstn_in = 1'b1; step(2);
		`CHK("events", 5'h00, event_count_out)
		`CHK("count", 5'h14, alarm_count_out)
		`CHK("ptr", ep, alarm_ptr_out)
		rd(0, 0, 5'h00, x, 0);
		$display("power test done");
		summarize();
	end
endmodule
bind fault_event_logger fault_event_logger_props chk (
	.clock_in        (clock_in),
	.rstn_in         (rstn_in),
	.fault_strobe_in (fault_strobe_in),
	.nv_ptr_in       (nv_ptr_in),
	.nv_count_in     (nv_count_in),
	.rd_req_in       (rd_req_in),
	.rd_log_in       (rd_log_in),
	.rd_index_in     (rd_index_in),
	.disp_req_in     (disp_req_in),
	.rd_valid_out    (rd_valid_out),
	.rd_empty_out    (rd_empty_out),
	.disp_valid_out  (disp_valid_out),
	.alarm_ptr_out   (alarm_ptr_out),
	.alarm_count_out (alarm_count_out),
	.event_count_out (event_count_out)
);
